// [adc_cfg_pkg.sv]
// constants and carriers for the converter setup registers
package adc_cfg_pkg;
   // register map
   localparam logic [7:0] CONVERTER_CONFIG_ADDR = 8'hBC;
   // no address is printed for this one; chosen two below the config register
   localparam logic [7:0] NEG_INPUT_SELECT_ADDR = 8'hBA;
   // field layout
   localparam int          CLKDIV_LSB          = 3;
   localparam int          CLKDIV_W            = 5;
   localparam int          LJUST_BIT           = 2;
   localparam int          NEG_CODE_W          = 5;
   // reset values
   localparam logic [4:0] NEG_CODE_RST        = 5'h00;
   localparam logic [4:0] CLKDIV_RST          = 5'h1F;
   localparam logic       LJUST_RST           = 1'b0;
   // negative input codes
   localparam logic [4:0] NEG_LAST_PIN        = 5'h14;
   localparam logic [4:0] NEG_VREF            = 5'h1E;
   localparam logic [4:0] NEG_GND             = 5'h1F;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_type;

   typedef struct packed {
      logic       pin_sel;
      logic [4:0] pin_index;
      logic       vref_sel;
      logic       gnd_sel;
      logic       reserved;
      logic       single_ended;
   } neg_route_type;
endpackage

// [sar_clock_gen.sv]
// conversion clock divider from the core clock
`timescale 1ns/10ps
`default_nettype none
module sar_clock_gen (
   // clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   // divider setting
   input  wire logic [4:0] i_div,
   // conversion clock
   output logic            o_conv_clk,
   output logic            o_conv_tick
);
   typedef struct packed {
      logic [5:0] cnt;
      logic       clk;
      logic       tick;
   } state_type;

   state_type st_r;
   state_type st_nxt;

   logic [5:0] period;

   always_comb begin
      period = {1'b0, i_div} + 6'h01;
      st_nxt = st_r;
      st_nxt.tick = 1'b0;
      // divide by setting + 1; high for the first (setting + 1) / 2 cycles, rounded down, of each period; setting 0 holds it high
      if (st_r.cnt >= period - 6'h01) begin // RULE3
         st_nxt.cnt  = 6'h00;
         st_nxt.tick = 1'b1;
      end else begin
         st_nxt.cnt = st_r.cnt + 6'h01;
      end
      st_nxt.clk = (st_nxt.cnt < (period >> 1)) || (i_div == 5'h00); // RULE3
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_conv_clk  = st_r.clk;
   assign o_conv_tick = st_r.tick;
endmodule
`default_nettype wire

// [adc_mux_and_config_regs.sv]
// negative input select and converter configuration registers
//
// Notes on behaviour
// RULE1: negative code 0..20 picks port pins, 21..29 reserved, 30 vref, 31 ground.
// RULE2: config bits 7..3 hold the 5-bit conversion clock setting, read/write.
// RULE3: conversion clock is core clock divided by setting plus one.
// RULE4: config bit 2 clear right-justifies the result, set left-justifies.
// RULE5: unused bits of both registers read zero and ignore writes.
`timescale 1ns/10ps
`default_nettype none
module adc_mux_and_config_regs
   import adc_cfg_pkg::*;
(
   // clock and reset
   input  wire logic                    i_clk,
   input  wire logic                    i_rst,
   // special-function register bus
   input  wire adc_cfg_pkg::sfr_req_type i_sfr,
   output logic [7:0]                   o_rdata,
   output logic                         o_hit,
   // to the converter core
   output adc_cfg_pkg::neg_route_type   o_neg_route,
   output logic                         o_left_justify_sel,
   output logic                         o_conversion_clock,
   output logic                         o_conversion_tick
);
   import adc_cfg_pkg::*;

   typedef struct packed {
      logic [4:0]    neg_input_code;
      logic [4:0]    sar_clock_divider;
      logic          left_justify_sel;
      logic [7:0]    rdata;
      logic          hit;
      neg_route_type route;
   } state_type;

   state_type st_r;
   state_type st_nxt;

   // decode a negative input code into its route
   function automatic neg_route_type decode_neg(input logic [4:0] code);
      neg_route_type r;
      r              = '0;
      r.pin_sel      = (code <= NEG_LAST_PIN); // RULE1
      r.pin_index    = r.pin_sel ? code : 5'h00;
      r.vref_sel     = (code == NEG_VREF);
      r.gnd_sel      = (code == NEG_GND);
      r.reserved     = !r.pin_sel && !r.vref_sel && !r.gnd_sel;
      r.single_ended = r.gnd_sel; // RULE1
      return r;
   endfunction

   always_comb begin
      st_nxt       = st_r;
      st_nxt.hit   = 1'b0;
      st_nxt.rdata = 8'h00;
      if (i_sfr.wr) begin
         case (i_sfr.addr)
            NEG_INPUT_SELECT_ADDR: begin
               // upper bits dropped on write
               st_nxt.neg_input_code = i_sfr.wdata[NEG_CODE_W-1:0]; // RULE5
            end
            CONVERTER_CONFIG_ADDR: begin
               st_nxt.sar_clock_divider =
                  i_sfr.wdata[CLKDIV_LSB +: CLKDIV_W]; // RULE2
               st_nxt.left_justify_sel = i_sfr.wdata[LJUST_BIT]; // RULE4
            end
            default: begin
               st_nxt.hit = 1'b0;
            end
         endcase
      end
      if (i_sfr.rd) begin
         case (i_sfr.addr)
            NEG_INPUT_SELECT_ADDR: begin
               st_nxt.hit   = 1'b1;
               st_nxt.rdata = {3'b000, st_r.neg_input_code}; // RULE5
            end
            CONVERTER_CONFIG_ADDR: begin
               st_nxt.hit   = 1'b1;
               st_nxt.rdata = {st_r.sar_clock_divider, // RULE2
                               st_r.left_justify_sel, 2'b00}; // RULE5
            end
            default: begin
               st_nxt.rdata = 8'h00;
            end
         endcase
      end
      // route registered so the mux sees one stable code per cycle
      st_nxt.route = decode_neg(st_nxt.neg_input_code);
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         st_r                   <= '0;
         st_r.neg_input_code    <= NEG_CODE_RST;
         st_r.sar_clock_divider <= CLKDIV_RST;
         st_r.left_justify_sel  <= LJUST_RST;
         st_r.route             <= decode_neg(NEG_CODE_RST);
      end else begin
         st_r <= st_nxt;
      end
   end

   sar_clock_gen u_sar_clock_gen (
      .i_clk       (i_clk),
      .i_rst       (i_rst),
      .i_div       (st_r.sar_clock_divider),
      .o_conv_clk  (o_conversion_clock),
      .o_conv_tick (o_conversion_tick)
   );

   assign o_rdata            = st_r.rdata;
   assign o_hit              = st_r.hit;
   assign o_neg_route        = st_r.route;
   assign o_left_justify_sel = st_r.left_justify_sel; // RULE4
endmodule
`default_nettype wire

// [adc_mux_and_config_regs_asserts.sv]
// port assertions for the converter setup registers
`timescale 1ns/10ps
`default_nettype none
module adc_regs_chk
   import adc_cfg_pkg::*;
(
   // clock and reset
   input  wire logic                       i_clk,
   input  wire logic                       i_rst,
   // observed ports
   input  wire adc_cfg_pkg::sfr_req_type   i_sfr,
   input  wire logic [7:0]                 o_rdata,
   input  wire logic                       o_hit,
   input  wire adc_cfg_pkg::neg_route_type o_neg_route,
   input  wire logic                       o_left_justify_sel,
   input  wire logic                       o_conversion_tick
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   wire wn = i_sfr.wr && i_sfr.addr == NEG_INPUT_SELECT_ADDR;
   wire wc = i_sfr.wr && i_sfr.addr == CONVERTER_CONFIG_ADDR;
   wire rn = i_sfr.rd && i_sfr.addr == NEG_INPUT_SELECT_ADDR;
   wire rc = i_sfr.rd && i_sfr.addr == CONVERTER_CONFIG_ADDR;
   property p_single;
      wn |=> o_neg_route.single_ended == ($past(i_sfr.wdata[4:0]) == NEG_GND);
   endproperty
   a_single: assert property (p_single) else $error("mode wrong");
   property p_ljust;
      wc |=> o_left_justify_sel == $past(i_sfr.wdata[LJUST_BIT]);
   endproperty
   a_ljust: assert property (p_ljust) else $error("justify wrong");
   property p_rd_neg;
      rn |=> o_hit && o_rdata[7:5] == 3'h0;
   endproperty
   a_rd_neg: assert property (p_rd_neg) else $error("select read");
   property p_div;
      wc ##1 !i_sfr.wr ##1 rc |=> o_rdata[1:0] == 2'h0 &&
         o_rdata[7:3] == $past(i_sfr.wdata[7:3], 3);
   endproperty
   a_div: assert property (p_div) else $error("config read");
   // a zero setting must tick on the third cycle after its write when the two cycles between carry no write
   property p_tick;
      wc && i_sfr.wdata[7:3] == 5'h00 ##1 !i_sfr.wr [*2] |=> o_conversion_tick;
   endproperty
   a_tick: assert property (p_tick) else $error("tick missing");
   c_gnd: cover property (o_neg_route.gnd_sel);
   c_res: cover property (o_neg_route.reserved);
   c_lj: cover property ($rose(o_left_justify_sel));
endmodule
`default_nettype wire

// [adc_mux_and_config_regs_tb.sv]
// self-checking bench for the converter setup registers
`timescale 1ns/10ps
`default_nettype none
module adc_mux_and_config_regs_tb;
   import adc_cfg_pkg::*;
   logic          i_clk = 0;
   logic          i_rst = 1;
   sfr_req_type   i_sfr = '0;
   logic [7:0]    o_rdata, d;
   logic          o_hit, o_left_justify_sel, o_conversion_clock;
   logic          o_conversion_tick;
   neg_route_type o_neg_route;
   int            mismatches = 0, n_compared = 0, cyc = 0, k, h;
   logic [4:0]    sv[4] = '{5'h00, 5'h01, 5'h06, 5'h1F};
   always #2.5 i_clk = ~i_clk;
   adc_mux_and_config_regs dut (.i_clk(i_clk), .i_rst(i_rst), .i_sfr(i_sfr),
      .o_rdata(o_rdata), .o_hit(o_hit), .o_neg_route(o_neg_route),
      .o_left_justify_sel(o_left_justify_sel),
      .o_conversion_clock(o_conversion_clock),
      .o_conversion_tick(o_conversion_tick));
   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [15:0] g, x);
      n_compared++;
      if (g !== x) begin
         mismatches++;
         $display("ERROR %0t got %h exp %h", $time, g, x);
      end
   endtask
   // one access, then an idle cycle so strobes never merge
   task automatic acc(input logic w, input logic [7:0] a, x, e);
      @(posedge i_clk);
      i_sfr <= '{w, !w, a, x};
      @(posedge i_clk);
      i_sfr <= '0;
      #1;
      if (!w) chk({7'h00, a == 8'hBA || a == 8'hBC, e}, {7'h00, o_hit, o_rdata});
   endtask
   function automatic logic [15:0] route(input int c);
      return {6'h00, c < 21, c < 21 ? 5'(c) : 5'h00, c == 30, c == 31,
         c > 20 && c < 30, c == 31};
   endfunction
   always @(posedge i_clk) if (++cyc > 5000) begin
      mismatches++;
      print_verdict();
   end
   initial begin
      void'($urandom(17051));
      repeat (12) @(posedge i_clk);
      i_rst <= 0;
      acc(0, 8'hBA, 0, {3'h0, NEG_CODE_RST});
      acc(0, 8'hBC, 0, {CLKDIV_RST, LJUST_RST, 2'h0});
      for (int c = 0; c < 32; c++) begin
         d = $urandom;
         d[4:0] = 5'(c);
         acc(1, 8'hBA, d, 0);
         chk({6'h00, o_neg_route}, route(c));
         acc(0, 8'hBA, 0, {3'h0, d[4:0]});
      end
      acc(1, 8'hBB, 8'hFF, 0);
      acc(0, 8'hBA, 0, 8'h1F);
      acc(0, 8'hBB, 0, 8'h00);
      foreach (sv[i]) begin
         d = {sv[i], 3'($urandom)};
         acc(1, 8'hBC, d, 0);
         chk({15'h0, o_left_justify_sel}, {15'h0, d[2]});
         acc(0, 8'hBC, 0, d & 8'hFC);
         // measure tick to tick, never from the change itself
         do begin
            @(posedge i_clk);
            #1;
         end while (!o_conversion_tick);
         k = 0;
         h = 0;
         do begin
            @(posedge i_clk);
            #1;
            k++;
            h += o_conversion_clock;
         end while (!o_conversion_tick && k < 40);
         chk(16'(k), 16'(sv[i]) + 16'h1);
         chk(16'(h), sv[i] == 0 ? 16'h1 : 16'((sv[i] + 1) / 2));
      end
      print_verdict();
   end
endmodule
bind adc_mux_and_config_regs adc_regs_chk u_chk (.i_clk(i_clk),
   .i_rst(i_rst), .i_sfr(i_sfr), .o_rdata(o_rdata), .o_hit(o_hit),
   .o_neg_route(o_neg_route), .o_left_justify_sel(o_left_justify_sel),
   .o_conversion_tick(o_conversion_tick));
`default_nettype wire
